// *** testbench/alu_asserts.sv ***
// checker: bus handshake and response properties of the datapath
`timescale 1ns/100ps
module alu_asserts (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [1:0] AVS_RESPONSE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic req, ack, map;
  assign req = AVS_READ | AVS_WRITE;
  assign ack = req && !AVS_WAITREQUEST;
  assign map = AVS_ADDRESS <= 6'h28 && AVS_ADDRESS[1:0] == 2'h0;
  sequence take_s; req && AVS_WAITREQUEST; endsequence
  sequence ack_s; req && !AVS_WAITREQUEST; endsequence
  wait_one_a: assert property (take_s |=> ack_s ##1 !AVS_WAITREQUEST) else $error("wait not one cycle");
  idle_wait_a: assert property (!req |-> !AVS_WAITREQUEST) else $error("wait while idle");
  first_wait_a: assert property ($rose(req) |-> take_s) else $error("no wait cycle");
  bad_resp_a: assert property (ack && !map |-> AVS_RESPONSE == 2'h2) else $error("unmapped not flagged");
  ok_resp_a: assert property (ack && map |-> AVS_RESPONSE == 2'h0) else $error("mapped flagged");
  bad_read_a: assert property (ack && AVS_READ && !map |-> AVS_READDATA == 32'h0) else $error("unmapped data");
  flag_width_a: assert property (ack && AVS_READ && AVS_ADDRESS == 6'h10 |-> AVS_READDATA[31:8] == 24'h0)
    else $error("flags too wide");
  reset_quiet_a: assert property ($fell(RST) |-> AVS_READDATA == 32'h0 && AVS_RESPONSE == 2'h0)
    else $error("bus not cleared");
endmodule : alu_asserts
bind bcd_sub_extend_flag_alu alu_asserts u_alu_asserts (.CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE));

// *** testbench/tb.sv ***
// testbench: random and corner runs of every datapath operation
`timescale 1ns/100ps
module tb;
  logic CLOCK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [5:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, r;
  logic [3:0] AVS_BYTEENABLE;
  logic [1:0] AVS_RESPONSE;
  int miscompares, cmp_count, cyc;
  bcd_sub_extend_flag_alu u_bcd_sub_extend_flag_alu (.CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE));
  initial begin
    CLOCK = 0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // request held until waitrequest is sampled low; no assumed latency
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    r = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask : acc
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rd
  // extra idle edge: results land one edge after the control write
  task automatic run(input logic [3:0] o, input logic w, input logic [2:0] sel, input logic [7:0] imm);
    acc(1'b1, alu_pkg::REG_CTRL, {1'b1, 7'h0, imm, 5'h0, sel, 3'h0, w, o});
    @(posedge CLOCK);
  endtask : run
  function automatic logic [16:0] bcd(input logic [15:0] d, input logic [15:0] s, input logic b, input logic w);
    int t;
    bcd = 17'h0;
    for (int i = 0; i < (w ? 4 : 2); i++) begin
      t = int'(d[i*4+:4]) - int'(s[i*4+:4]) - int'(b);
      b = t < 0;
      bcd[i*4+:4] = 4'(b ? t + 10 : t);
    end
    bcd[16] = b;
  endfunction : bcd
  function automatic logic [7:0] sz(input logic [7:0] f, input logic [15:0] v, input logic w);
    sz = f;
    sz[alu_pkg::FLG_SIGN] = w ? v[15] : v[7];
    sz[alu_pkg::FLG_ZERO] = w ? v == 16'h0 : v[7:0] == 8'h0;
  endfunction : sz
  function automatic logic [15:0] rbcd();
    for (int k = 0; k < 4; k++) rbcd[k*4+:4] = 4'($urandom_range(9));
  endfunction : rbcd
  initial begin
    logic [15:0] d, s, p;
    logic [16:0] e;
    logic [7:0] f, m;
    logic [2:0] sel;
    logic w;
    logic [3:0] o;
    RST = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 6'h0;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'hf;
    void'($urandom(71));
    repeat (8) @(posedge CLOCK);
    RST <= 1'b0;
    rd(alu_pkg::REG_SP, alu_pkg::SP_RESET);
    rd(alu_pkg::REG_FLAGS, alu_pkg::FLAGS_RESET);
    acc(1'b1, 6'h3c, 32'h5);
    rd(6'h3c, 32'h0);
    $display("reset done");
    for (int i = 0; i < 16; i++) begin
      d = (i == 1) ? 16'h0 : rbcd();
      s = (i == 0) ? d : (i == 1) ? 16'h1 : rbcd();
      w = 1'($urandom);
      f = 8'($urandom);
      o = 4'($urandom_range(2, 1));
      acc(1'b1, alu_pkg::REG_FLAGS, f);
      acc(1'b1, alu_pkg::REG_DST, d);
      acc(1'b1, alu_pkg::REG_SRC, s);
      run(o, w, 3'h0, 8'h0);
      e = bcd(d, s, o == 4'h1 && !f[alu_pkg::FLG_CARRY], w);
      rd(alu_pkg::REG_RESULT, e[15:0]);
      f = sz(f, e[15:0], w);
      f[alu_pkg::FLG_CARRY] = !e[16];
      rd(alu_pkg::REG_FLAGS, f);
    end
    $display("decimal done");
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      f = 8'($urandom);
      acc(1'b1, alu_pkg::REG_FLAGS, f);
      acc(1'b1, alu_pkg::REG_DST, d);
      run(alu_pkg::OP_SIGN_WIDEN, i[0], 3'h0, 8'h0);
      if (i[0]) rd(alu_pkg::REG_DATA_TWO, {16{d[15]}});
      else rd(alu_pkg::REG_RESULT, {{8{d[7]}}, d[7:0]});
      if (!i[0]) f = sz(f, {8'h0, d[7:0]}, 1'b0);
      rd(alu_pkg::REG_FLAGS, f);
    end
    for (int i = 0; i < 16; i++) begin
      f = 8'($urandom);
      acc(1'b1, alu_pkg::REG_FLAGS, f);
      run(i[3] ? alu_pkg::OP_FLAG_SET : alu_pkg::OP_FLAG_CLEAR, 1'b0, i[2:0], 8'h0);
      f[i[2:0]] = i[3];
      rd(alu_pkg::REG_FLAGS, f);
    end
    $display("widen and flags done");
    for (int i = 0; i < 14; i++) begin
      sel = 3'(i % 7);
      w = i >= 7;
      d = (i == 2 || i == 12) ? 16'hffff : 16'($urandom);
      f = 8'($urandom);
      acc(1'b1, alu_pkg::REG_FLAGS, f);
      acc(1'b1, alu_pkg::REG_DST, d);
      run(alu_pkg::OP_ADD_ONE, w, sel, 8'h0);
      e = w ? 16'(d + 16'h1) : 8'(d[7:0] + 8'h1);
      if (w != (sel >= 3'h5)) begin
        acc(1'b0, alu_pkg::REG_STATUS, 32'h0);
        chk(r[16], 1'b1);
      end
      else rd(alu_pkg::REG_RESULT, e[15:0]);
      if (w == (sel >= 3'h5)) f = sz(f, e[15:0], w);
      rd(alu_pkg::REG_FLAGS, f);
    end
    $display("add one done");
    for (int i = 0; i < 3; i++) begin
      d = 16'($urandom);
      s = 16'($urandom);
      p = 16'($urandom);
      f = 8'($urandom);
      m = (i == 0) ? 8'h0 : (i == 1) ? 8'hff : 8'($urandom);
      acc(1'b1, alu_pkg::REG_SP, d);
      acc(1'b1, alu_pkg::REG_FB, s);
      acc(1'b1, alu_pkg::REG_FLAGS, f);
      run(alu_pkg::OP_FRAME_BUILD, 1'b1, 3'h0, m);
      acc(1'b0, alu_pkg::REG_STATUS, 32'h0);
      chk(r[15:0], s);
      rd(alu_pkg::REG_FB, 16'(d - 16'h2));
      rd(alu_pkg::REG_SP, 16'(d - 16'h2 - m));
      rd(alu_pkg::REG_FLAGS, f);
      acc(1'b1, alu_pkg::REG_STACK_IN, s);
      acc(1'b1, alu_pkg::REG_SRC, p);
      run(alu_pkg::OP_FRAME_RELEASE, 1'b1, 3'h0, 8'h0);
      rd(alu_pkg::REG_SP, 16'(d + 16'h4));
      rd(alu_pkg::REG_FB, s);
      rd(alu_pkg::REG_PC, p);
      rd(alu_pkg::REG_FLAGS, f);
    end
    $display("frame done");
    wrap_up();
  end
endmodule : tb

// *** verilog/alu_pkg.sv ***
// package: operation codes, flag positions and bus map for the decimal/frame/flag datapath
package alu_pkg;
  // ----------------------------------------
  // operations
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_BCD_SUB_BORROW,
    OP_BCD_SUB,
    OP_FRAME_BUILD,
    OP_FRAME_RELEASE,
    OP_SIGN_WIDEN,
    OP_FLAG_CLEAR,
    OP_FLAG_SET,
    OP_ADD_ONE
  } op_t;
  // ----------------------------------------
  // destination select for add-one
  // ----------------------------------------
  localparam logic [2:0] DST_DATA_ZERO_LOW = 3'h0;
  localparam logic [2:0] DST_DATA_ZERO_HIGH = 3'h1;
  localparam logic [2:0] DST_MEM_DSP8_SB = 3'h2;
  localparam logic [2:0] DST_MEM_DSP8_FB = 3'h3;
  localparam logic [2:0] DST_MEM_ABS16 = 3'h4;
  localparam logic [2:0] DST_ADDR_FIRST = 3'h5;
  localparam logic [2:0] DST_ADDR_SECOND = 3'h6;
  // ----------------------------------------
  // flag register bit positions
  // ----------------------------------------
  localparam int FLG_CARRY = 0;
  localparam int FLG_DEBUG = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_SIGN = 3;
  localparam int FLG_BANK = 4;
  localparam int FLG_OVERFLOW = 5;
  localparam int FLG_INT_EN = 6;
  localparam int FLG_STACK_SEL = 7;
  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_SRC = 6'h04;
  localparam logic [5:0] REG_DST = 6'h08;
  localparam logic [5:0] REG_RESULT = 6'h0c;
  localparam logic [5:0] REG_FLAGS = 6'h10;
  localparam logic [5:0] REG_DATA_TWO = 6'h14;
  localparam logic [5:0] REG_SP = 6'h18;
  localparam logic [5:0] REG_FB = 6'h1c;
  localparam logic [5:0] REG_PC = 6'h20;
  localparam logic [5:0] REG_STATUS = 6'h24;
  localparam logic [5:0] REG_STACK_IN = 6'h28;
  // ctrl fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_WORD = 4;
  localparam int CTRL_SEL_LSB = 8;
  localparam int CTRL_IMM_LSB = 16;
  localparam int CTRL_GO = 31;
  // reset values
  localparam logic [15:0] SP_RESET = 16'h0400;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
endpackage : alu_pkg

// *** verilog/bcd_sub_extend_flag_alu.sv ***
// datapath for decimal subtract, frame build/release, sign widen, flag set/clear and add-one
// Functional notes
// - decimal subtract with borrow gives dest minus src minus inverted carry, written to dest.
// - decimal subtract gives dest minus src ignoring carry, written to dest.
// - for decimal subtracts and add-one the sign flag copies the result msb.
// - for decimal subtracts and add-one the zero flag is set when the result is zero.
// - for decimal subtracts carry is set when no borrow out of the top digit occurs.
// - frame build allocates an 8-bit immediate frame size and keeps all flags.
// - frame release drops the frame and returns, keeping all flags.
// - byte sign widen copies bit 7 into the upper byte of a 16-bit result.
// - word sign widen extends data_reg_zero to 32 bits with the upper word in data_reg_two.
// - sign widen updates sign and zero only in byte size.
// - flag clear writes 0 to one selected flag bit only.
// - flag set writes 1 to one selected flag bit only.
// - add-one adds 1 to dest, leaving carry and overflow untouched.
// - add-one takes byte size only for byte operands and word size only for the address registers.
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module bcd_sub_extend_flag_alu (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [1:0] AVS_RESPONSE
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [15:0] src_q, src_d;
  logic [15:0] dst_q, dst_d;
  logic [15:0] res_q, res_d;
  logic [7:0] flags_q, flags_d;
  logic [15:0] dtwo_q, dtwo_d;
  logic [15:0] sp_q, sp_d;
  logic [15:0] fb_q, fb_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] stk_in_q, stk_in_d;
  logic [15:0] push_q, push_d;
  logic illegal_q, illegal_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] resp_q, resp_d;

  // ----------------------------------------
  // decimal subtract, one digit per stage
  // ----------------------------------------
  logic [4:0] borrow;
  logic [15:0] bcd_diff;
  logic in_borrow;
  logic word_sz;
  alu_pkg::op_t op;
  assign op = alu_pkg::op_t'(ctrl_q[alu_pkg::CTRL_OP_LSB +: 4]);
  assign word_sz = ctrl_q[alu_pkg::CTRL_WORD];
  assign in_borrow = (op == alu_pkg::OP_BCD_SUB_BORROW) ? ~flags_q[alu_pkg::FLG_CARRY] : 1'b0;
  assign borrow[0] = in_borrow;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_digit
      logic [4:0] raw;
      assign raw = {1'b0, dst_q[4*g +: 4]} - {1'b0, src_q[4*g +: 4]} - {4'h0, borrow[g]};
      assign bcd_diff[4*g +: 4] = raw[4] ? 4'((raw[3:0]) - 4'h6) : raw[3:0];
      assign borrow[g+1] = raw[4];
    end
  endgenerate

  // ----------------------------------------
  // execute and bus
  // ----------------------------------------
  logic go;
  logic [7:0] sel_onehot;
  logic [15:0] r;
  logic [15:0] inc16;
  logic [2:0] dsel;
  assign go = ctrl_q[alu_pkg::CTRL_GO];
  assign dsel = ctrl_q[alu_pkg::CTRL_SEL_LSB +: 3];
  assign inc16 = 16'(dst_q + 16'h0001);

  always_comb begin
    ctrl_d = ctrl_q;
    src_d = src_q;
    dst_d = dst_q;
    res_d = res_q;
    flags_d = flags_q;
    dtwo_d = dtwo_q;
    sp_d = sp_q;
    fb_d = fb_q;
    pc_d = pc_q;
    stk_in_d = stk_in_q;
    push_d = push_q;
    illegal_d = illegal_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    resp_d = resp_q;
    r = 16'h0000;
    sel_onehot = 8'h01 << ctrl_q[alu_pkg::CTRL_SEL_LSB +: 3];
    if (go) begin
      // one operation per cycle; go self-clears so a write fires it once
      ctrl_d[alu_pkg::CTRL_GO] = 1'b0;
      illegal_d = 1'b0;
      case (op)
        alu_pkg::OP_BCD_SUB_BORROW, alu_pkg::OP_BCD_SUB: begin
          r = word_sz ? bcd_diff : {8'h00, bcd_diff[7:0]};
          res_d = r;
          dst_d = r;
          flags_d[alu_pkg::FLG_SIGN] = word_sz ? r[15] : r[7];
          flags_d[alu_pkg::FLG_ZERO] = word_sz ? (r == 16'h0000) : (r[7:0] == 8'h00);
          flags_d[alu_pkg::FLG_CARRY] = word_sz ? ~borrow[4] : ~borrow[2];
        end
        alu_pkg::OP_FRAME_BUILD: begin
          push_d = fb_q;
          fb_d = 16'(sp_q - 16'h0002);
          sp_d = 16'(sp_q - 16'h0002 - {8'h00, ctrl_q[alu_pkg::CTRL_IMM_LSB +: 8]});
        end
        alu_pkg::OP_FRAME_RELEASE: begin
          // saved base comes in through the stack-in word, return address through the src word
          sp_d = 16'(fb_q + 16'h0006);
          fb_d = stk_in_q;
          pc_d = src_q;
        end
        alu_pkg::OP_SIGN_WIDEN: begin
          if (word_sz) begin
            dtwo_d = {16{dst_q[15]}};
            res_d = dst_q;
          end else begin
            r = {{8{dst_q[7]}}, dst_q[7:0]};
            res_d = r;
            dst_d = r;
            flags_d[alu_pkg::FLG_SIGN] = r[15];
            flags_d[alu_pkg::FLG_ZERO] = (r == 16'h0000);
          end
        end
        alu_pkg::OP_FLAG_CLEAR: flags_d = flags_q & ~sel_onehot;
        alu_pkg::OP_FLAG_SET: flags_d = flags_q | sel_onehot;
        alu_pkg::OP_ADD_ONE: begin
          // operand class must match size, else refused with no change
          if ((word_sz && (dsel == alu_pkg::DST_ADDR_FIRST || dsel == alu_pkg::DST_ADDR_SECOND)) ||
              (!word_sz && dsel <= alu_pkg::DST_MEM_ABS16)) begin
            r = word_sz ? inc16 : {8'h00, inc16[7:0]};
            res_d = r;
            dst_d = r;
            flags_d[alu_pkg::FLG_SIGN] = word_sz ? r[15] : r[7];
            flags_d[alu_pkg::FLG_ZERO] = word_sz ? (r == 16'h0000) : (r[7:0] == 8'h00);
          end else begin
            illegal_d = 1'b1;
          end
        end
        default: illegal_d = 1'b0;
      endcase
    end
    // avalon slave: one wait cycle, answer on the second edge
    if ((AVS_READ || AVS_WRITE) && !ack_q) begin
      ack_d = 1'b1;
      resp_d = 2'h0;
      rdata_d = 32'h0000_0000;
      case (AVS_ADDRESS)
        alu_pkg::REG_CTRL: rdata_d = ctrl_q;
        alu_pkg::REG_SRC: rdata_d = {16'h0000, src_q};
        alu_pkg::REG_DST: rdata_d = {16'h0000, dst_q};
        alu_pkg::REG_RESULT: rdata_d = {16'h0000, res_q};
        alu_pkg::REG_FLAGS: rdata_d = {24'h000000, flags_q};
        alu_pkg::REG_DATA_TWO: rdata_d = {16'h0000, dtwo_q};
        alu_pkg::REG_SP: rdata_d = {16'h0000, sp_q};
        alu_pkg::REG_FB: rdata_d = {16'h0000, fb_q};
        alu_pkg::REG_PC: rdata_d = {16'h0000, pc_q};
        alu_pkg::REG_STATUS: rdata_d = {15'h0000, illegal_q, push_q};
        alu_pkg::REG_STACK_IN: rdata_d = {16'h0000, stk_in_q};
        default: resp_d = 2'h2;
      endcase
      if (AVS_WRITE) begin
        rdata_d = 32'h0000_0000;
        // bus write wins over the datapath update in the same cycle
        case (AVS_ADDRESS)
          alu_pkg::REG_CTRL: ctrl_d = AVS_WRITEDATA;
          alu_pkg::REG_SRC: src_d = AVS_WRITEDATA[15:0];
          alu_pkg::REG_DST: dst_d = AVS_WRITEDATA[15:0];
          alu_pkg::REG_FLAGS: flags_d = AVS_WRITEDATA[7:0];
          alu_pkg::REG_DATA_TWO: dtwo_d = AVS_WRITEDATA[15:0];
          alu_pkg::REG_SP: sp_d = AVS_WRITEDATA[15:0];
          alu_pkg::REG_FB: fb_d = AVS_WRITEDATA[15:0];
          alu_pkg::REG_PC: pc_d = AVS_WRITEDATA[15:0];
          alu_pkg::REG_STACK_IN: stk_in_d = AVS_WRITEDATA[15:0];
          default: resp_d = resp_d;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl_q <= 32'h0000_0000;
      src_q <= 16'h0000;
      dst_q <= 16'h0000;
      res_q <= 16'h0000;
      flags_q <= alu_pkg::FLAGS_RESET;
      dtwo_q <= 16'h0000;
      sp_q <= alu_pkg::SP_RESET;
      fb_q <= 16'h0000;
      pc_q <= 16'h0000;
      stk_in_q <= 16'h0000;
      push_q <= 16'h0000;
      illegal_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      src_q <= src_d;
      dst_q <= dst_d;
      res_q <= res_d;
      flags_q <= flags_d;
      dtwo_q <= dtwo_d;
      sp_q <= sp_d;
      fb_q <= fb_d;
      pc_q <= pc_d;
      stk_in_q <= stk_in_d;
      push_q <= push_d;
      illegal_q <= illegal_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      resp_q <= resp_d;
    end
  end

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
  assign AVS_READDATA = rdata_q;
  assign AVS_RESPONSE = resp_q;
endmodule : bcd_sub_extend_flag_alu
